/* File: include/ecp_defs.vh */
// constants for the encoder comms pass-through block
`ifndef ECP_DEFS_VH
`define ECP_DEFS_VH
// register byte offsets
`define ECP_ADR_TX 8'h00
`define ECP_ADR_RX 8'h04
`define ECP_ADR_CTRL 8'h08
`define ECP_ADR_IRQ_STAT 8'h0C
`define ECP_ADR_IRQ_MASK 8'h10
// transmit and receive word flag positions
`define ECP_TX_XFER 15
`define ECP_TX_LAST 14
`define ECP_TX_FIRST 13
`define ECP_RX_VALID 15
`define ECP_RX_LAST 14
`define ECP_RX_STATUS 13
// control fields
`define ECP_CTRL_PCD 0
`define ECP_CTRL_SYNC 1
// status error bits
`define ECP_ERR_LEN 0
`define ECP_ERR_OVF 1
`define ECP_ERR_CMD 2
`define ECP_ERR_ENC 3
`define ECP_ERR_SUM 4
`define ECP_ERR_TMO 5
// interrupt bits
`define ECP_IRQ_DONE 0
`define ECP_IRQ_ERR 1
`define ECP_IRQ_TAKEN 2
// reset values
`define ECP_CTRL_RST 2'h0
`define ECP_MASK_RST 3'h0
// buffer size, sync command limit and response lengths
`define ECP_BUF_BYTES 5'h10
`define ECP_SYNC_MAX_CMD 5'h04
`define ECP_SYNC_POS_LEN 5'h08
`define ECP_SYNC_OTHER_LEN 5'h03
// command codes
`define ECP_SYNC_SEND_POS 8'h00
`define ECP_SYNC_SEL_MEM 8'h01
`define ECP_SYNC_RECV_PAR 8'h03
`define ECP_SYNC_SEND_PAR 8'h04
`define ECP_SYNC_RESET 8'h05
`define ECP_ASYNC_READ_POS 8'h42
// response timeout
`define ECP_TIMEOUT_US 200
`define ECP_CLK_MHZ 100
`define ECP_TIMEOUT_CYC (`ECP_TIMEOUT_US * `ECP_CLK_MHZ)
`endif

/* File: rtl/ecp_encoder_comms.v */
// encoder comms pass-through: wishbone registers, byte buffer, link side
`timescale 1ns/1ps
// Rules this block works to, with those of its host and of the encoder
// (RL1) host enables position check disable before using the channel
// (RL2) host writes transmit word only after it reads zero
// (RL3) async mode: last flag appends checksum and sends the message
// (RL4) full response received: first byte into receive word, valid set
// (RL5) after each host clear, next response byte loads until last
// (RL6) async first byte is encoder address, 0xff broadcasts
// (RL7) async read position answer: address, echo, four bytes, checksum
// (RL8) async data field command carries field, status, code bytes
// (RL9) sync command: code, address, data low, data high
// (RL10) sync codes 0x00, 0x01, 0x03, 0x04, 0x05 are accepted
// (RL11) sync position answer is eight bytes, least significant first
// (RL12) sync position command may be a single first-and-last byte
// (RL13) other sync commands answer three bytes: address, data low, high
// (RL14) transmit flags: 15 take byte, 14 last and send, 13 first
// (RL15) receive flags: 15 valid, 14 last, 13 status with error bits
// (RL16) device clears transmit word after moving its byte
// (RL17) messages over sixteen bytes, checksum included, flag an error
// (RL18) async checksum is exclusive-or of all preceding bytes
`include "ecp_defs.vh"
module ecp_encoder_comms #(
    parameter TIMEOUT_CYC = `ECP_TIMEOUT_CYC
) (
    // clock, reset, enable
    input wire clk,
    input wire rstn,
    input wire ce,
    // wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // encoder link, byte stream
    output reg [7:0] enc_tx_data,
    output reg enc_tx_last,
    output wire enc_tx_valid,
    input wire enc_tx_ready,
    input wire [7:0] enc_rx_data,
    input wire enc_rx_valid,
    input wire enc_rx_last,
    input wire enc_rx_err,
    // status
    output wire position_check_disable,
    output wire sync_link_mode,
    output wire irq
);
    localparam [1:0] ST_IDLE = 2'd0;
    localparam [1:0] ST_SEND = 2'd1;
    localparam [1:0] ST_WAIT = 2'd2;
    localparam [1:0] ST_DELIV = 2'd3;

    reg [1:0] state_q;
    reg [15:0] tx_q;
    reg [15:0] rx_q;
    reg [1:0] ctrl_q;
    reg [2:0] istat_q;
    reg [2:0] imask_q;
    reg [7:0] buf_q [0:15];
    reg [7:0] rbuf_q [0:15];
    reg [4:0] tcnt_q;
    reg [4:0] tidx_q;
    reg [4:0] rcnt_q;
    reg [4:0] ridx_q;
    reg [7:0] tsum_q;
    reg [7:0] rsum_q;
    reg tovf_q;
    reg rovf_q;
    reg [31:0] tmo_q;

    wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wr_ev = wb_req & wb_we_i;
    wire wr_tx = wr_ev & (wb_adr_i == `ECP_ADR_TX);
    wire wr_rx = wr_ev & (wb_adr_i == `ECP_ADR_RX);
    wire async_m = ~ctrl_q[`ECP_CTRL_SYNC];
    wire [7:0] tbyte = tx_q[7:0];
    wire first_in = tx_q[`ECP_TX_FIRST];
    // byte count including this one, restarted by the first flag
    wire [4:0] base_cnt = first_in ? 5'h00 : tcnt_q;
    wire [4:0] new_cnt = base_cnt + 5'h01;
    wire ovf_now = (first_in ? 1'b0 : tovf_q) | (base_cnt == `ECP_BUF_BYTES);
    wire [7:0] sum_now = (first_in ? 8'h00 : tsum_q) ^ tbyte;
    wire [7:0] cmd_now = first_in ? tbyte : buf_q[0];
    wire take = ~wr_tx & tx_q[`ECP_TX_XFER] & (state_q == ST_IDLE)
        & ctrl_q[`ECP_CTRL_PCD]; // RL1 RL2
    wire [4:0] rc_new = rcnt_q + 5'h01;
    wire [7:0] rsum_new = rsum_q ^ enc_rx_data;

    // accepted sync command codes
    function cmd_ok;
        input [7:0] c;
        begin
            cmd_ok = (c == `ECP_SYNC_SEND_POS) | (c == `ECP_SYNC_SEL_MEM)
                | (c == `ECP_SYNC_RECV_PAR) | (c == `ECP_SYNC_SEND_PAR)
                | (c == `ECP_SYNC_RESET); // RL10
        end
    endfunction

    // expected sync response length for a command
    function [4:0] sync_len;
        input [7:0] c;
        begin
            if (c == `ECP_SYNC_SEND_POS) begin
                sync_len = `ECP_SYNC_POS_LEN; // RL11
            end else begin
                sync_len = `ECP_SYNC_OTHER_LEN; // RL13
            end
        end
    endfunction

    // status word shown in the receive register
    function [15:0] stat_word;
        input [5:0] e;
        begin
            stat_word = {2'b00, 1'b1, 5'h00, 2'b00, e}; // RL15
        end
    endfunction

    // receive word carrying one response byte
    function [15:0] data_word;
        input [7:0] b;
        input l;
        begin
            data_word = {1'b1, l, 6'h00, b}; // RL15
        end
    endfunction

    reg [5:0] terr;
    reg [5:0] rerr;
    always @* begin
        terr = 6'h00;
        terr[`ECP_ERR_OVF] = ovf_now
            | (async_m & (new_cnt == `ECP_BUF_BYTES)); // RL17
        terr[`ECP_ERR_CMD] = ~async_m & ~cmd_ok(cmd_now);
        terr[`ECP_ERR_LEN] = ~async_m & (new_cnt > `ECP_SYNC_MAX_CMD)
            & (cmd_now != `ECP_SYNC_SEND_POS); // RL9 RL12
        rerr = 6'h00;
        rerr[`ECP_ERR_ENC] = enc_rx_err;
        rerr[`ECP_ERR_OVF] = rovf_q | (rcnt_q == `ECP_BUF_BYTES);
        rerr[`ECP_ERR_SUM] = async_m & (rsum_new != 8'h00); // RL18
        rerr[`ECP_ERR_LEN] = ~async_m & (rc_new != sync_len(buf_q[0]));
    end

    assign enc_tx_valid = (state_q == ST_SEND);
    assign position_check_disable = ctrl_q[`ECP_CTRL_PCD];
    assign sync_link_mode = ctrl_q[`ECP_CTRL_SYNC];
    assign irq = |(istat_q & imask_q);

    // wishbone answer: ack one cycle after the request, reads registered
    always @(posedge clk) begin
        if (!rstn) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else if (ce) begin
            wb_ack_o <= wb_req;
            if (wb_req) begin
                case (wb_adr_i)
                    `ECP_ADR_TX: wb_dat_o <= {16'h0000, tx_q};
                    `ECP_ADR_RX: wb_dat_o <= {16'h0000, rx_q};
                    `ECP_ADR_CTRL: wb_dat_o <= {30'h00000000, ctrl_q};
                    `ECP_ADR_IRQ_STAT: wb_dat_o <= {29'h00000000, istat_q};
                    `ECP_ADR_IRQ_MASK: wb_dat_o <= {29'h00000000, imask_q};
                    default: wb_dat_o <= 32'h00000000;
                endcase
            end
        end
    end

    // control, mask and interrupt status
    reg [2:0] iev;
    always @* begin
        iev = 3'h0;
        iev[`ECP_IRQ_TAKEN] = take;
        // when a status word is due, even one lost to a same-cycle receive write; not mid-response
        iev[`ECP_IRQ_ERR] = (take & tx_q[`ECP_TX_LAST] & (|terr))
            | ((state_q == ST_WAIT) & ce
            & ((enc_rx_valid & (enc_rx_last | enc_rx_err) & (|rerr))
            | (~enc_rx_valid & (tmo_q == 32'h00000000))));
        iev[`ECP_IRQ_DONE] = (state_q == ST_DELIV) & (rx_q == 16'h0000)
            & ~wr_rx & (ridx_q == rcnt_q);
    end

    always @(posedge clk) begin
        if (!rstn) begin
            ctrl_q <= `ECP_CTRL_RST;
            imask_q <= `ECP_MASK_RST;
            istat_q <= 3'h0;
        end else if (ce) begin
            if (wr_ev & (wb_adr_i == `ECP_ADR_CTRL) & wb_sel_i[0]) begin
                ctrl_q <= wb_dat_i[1:0];
            end
            if (wr_ev & (wb_adr_i == `ECP_ADR_IRQ_MASK) & wb_sel_i[0]) begin
                imask_q <= wb_dat_i[2:0];
            end
            // set wins over write-one-to-clear
            if (wr_ev & (wb_adr_i == `ECP_ADR_IRQ_STAT) & wb_sel_i[0]) begin
                istat_q <= (istat_q & ~wb_dat_i[2:0]) | iev;
            end else begin
                istat_q <= istat_q | iev;
            end
        end
    end

    // message engine
    always @(posedge clk) begin
        if (!rstn) begin
            state_q <= ST_IDLE;
            tx_q <= 16'h0000;
            rx_q <= 16'h0000;
            tcnt_q <= 5'h00;
            tidx_q <= 5'h00;
            rcnt_q <= 5'h00;
            ridx_q <= 5'h00;
            tsum_q <= 8'h00;
            rsum_q <= 8'h00;
            tovf_q <= 1'b0;
            rovf_q <= 1'b0;
            tmo_q <= 32'h00000000;
            enc_tx_data <= 8'h00;
            enc_tx_last <= 1'b0;
        end else if (ce) begin
            if (wr_tx) begin
                if (wb_sel_i[0]) tx_q[7:0] <= wb_dat_i[7:0];
                if (wb_sel_i[1]) tx_q[15:8] <= wb_dat_i[15:8];
            end
            if (wr_rx) begin
                if (wb_sel_i[0]) rx_q[7:0] <= wb_dat_i[7:0];
                if (wb_sel_i[1]) rx_q[15:8] <= wb_dat_i[15:8];
            end
            case (state_q)
                ST_IDLE: begin
                    if (take) begin
                        tx_q <= 16'h0000; // RL16
                        tcnt_q <= new_cnt; // RL14
                        tsum_q <= sum_now; // RL18
                        tovf_q <= ovf_now;
                        if (!ovf_now) buf_q[base_cnt[3:0]] <= tbyte;
                        if (first_in && !wr_rx) rx_q <= 16'h0000;
                        if (tx_q[`ECP_TX_LAST]) begin
                            if (|terr) begin
                                if (!wr_rx) rx_q <= stat_word(terr);
                            end else begin
                                if (async_m) begin
                                    buf_q[new_cnt[3:0]] <= sum_now; // RL3
                                    tcnt_q <= new_cnt + 5'h01;
                                end
                                tidx_q <= 5'h00;
                                enc_tx_data <= first_in ? tbyte : buf_q[0];
                                enc_tx_last <= ~async_m
                                    & (new_cnt == 5'h01);
                                state_q <= ST_SEND; // RL3
                            end
                        end
                    end
                end
                ST_SEND: begin
                    if (enc_tx_ready) begin
                        tidx_q <= tidx_q + 5'h01;
                        enc_tx_data <= buf_q[tidx_q[3:0] + 4'h1];
                        enc_tx_last <= (tidx_q + 5'h02 == tcnt_q);
                        if (enc_tx_last) begin
                            state_q <= ST_WAIT;
                            rcnt_q <= 5'h00;
                            rsum_q <= 8'h00;
                            rovf_q <= 1'b0;
                            tmo_q <= TIMEOUT_CYC;
                        end
                    end
                end
                ST_WAIT: begin
                    tmo_q <= tmo_q - 32'h00000001;
                    if (enc_rx_valid) begin
                        rcnt_q <= rc_new;
                        rsum_q <= rsum_new;
                        if (rcnt_q == `ECP_BUF_BYTES) begin
                            rovf_q <= 1'b1;
                        end else begin
                            rbuf_q[rcnt_q[3:0]] <= enc_rx_data; // RL7 RL11
                        end
                        if (enc_rx_last | enc_rx_err) begin
                            if (|rerr) begin
                                if (!wr_rx) rx_q <= stat_word(rerr);
                                state_q <= ST_IDLE;
                            end else begin
                                rx_q <= data_word(rcnt_q == 5'h00
                                    ? enc_rx_data : rbuf_q[0],
                                    rc_new == 5'h01); // RL4
                                ridx_q <= 5'h01;
                                state_q <= (rc_new == 5'h01) ? ST_IDLE
                                    : ST_DELIV;
                            end
                        end
                    end else if (tmo_q == 32'h00000000) begin
                        if (!wr_rx) rx_q <= stat_word(6'h20);
                        state_q <= ST_IDLE;
                    end
                end
                ST_DELIV: begin
                    if (ridx_q == rcnt_q) begin
                        if (rx_q == 16'h0000) state_q <= ST_IDLE;
                    end else if (rx_q == 16'h0000 && !wr_rx) begin
                        rx_q <= data_word(rbuf_q[ridx_q[3:0]],
                            ridx_q + 5'h01 == rcnt_q); // RL5
                        ridx_q <= ridx_q + 5'h01;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end
endmodule // ecp_encoder_comms

/* File: verif/ecp_encoder_comms_assertions.sv */
// assertion checker for the encoder comms pass-through block
`timescale 1ns/1ps
`include "ecp_defs.vh"
module ecp_encoder_comms_chk (
    // clock, reset, enable
    input wire clk,
    input wire rstn,
    input wire ce,
    // wishbone
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire [31:0] wb_dat_o,
    input wire wb_ack_o,
    // link and status
    input wire [7:0] enc_tx_data,
    input wire enc_tx_last,
    input wire enc_tx_valid,
    input wire enc_tx_ready,
    input wire position_check_disable,
    input wire sync_link_mode,
    input wire irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    wire wr = wb_ack_o && wb_we_i && wb_sel_i[0];
    sequence s_req;
        ce && wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_ack;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    a_ack_one_pulse: assert property (s_req |=> s_ack)
        else $error("ack missing or too long");
    a_ack_has_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    a_unmapped_reads_zero: assert property (wb_ack_o && !wb_we_i
        && wb_adr_i == 8'h14 |-> wb_dat_o == 32'h0) else $error("unmapped");
    a_ctrl_write: assert property (wr && wb_adr_i == `ECP_ADR_CTRL
        |-> position_check_disable == wb_dat_i[0]
        && sync_link_mode == wb_dat_i[1]) else $error("ctrl not written");
    a_send_needs_pcd: assert property (enc_tx_valid
        |-> position_check_disable) else $error("sent without disable");
    a_tx_held_stall: assert property (enc_tx_valid && !enc_tx_ready
        |=> enc_tx_valid && $stable(enc_tx_data) && $stable(enc_tx_last))
        else $error("link byte changed while stalled");
    a_send_stops_last: assert property (enc_tx_valid && enc_tx_ready
        && enc_tx_last |=> !enc_tx_valid) else $error("send past last");
    a_mask_off_quiet: assert property (wr && wb_adr_i == `ECP_ADR_IRQ_MASK
        && wb_dat_i[2:0] == 3'h0 |-> !irq) else $error("irq while masked");
endmodule // ecp_encoder_comms_chk
bind ecp_encoder_comms ecp_encoder_comms_chk ecp_encoder_comms_chk_i (.*);

/* File: verif/ecp_enc_model.sv */
// behavioural encoder on the far side of the byte link
`timescale 1ns/1ps
module ecp_enc_model (
    // clock and modes
    input wire clk,
    input wire sync,
    input wire slow,
    input wire mute,
    input wire bad,
    // bytes from the block
    input wire [7:0] tx_data,
    input wire tx_last,
    input wire tx_valid,
    output reg tx_ready,
    // bytes to the block
    output reg [7:0] rx_data,
    output reg rx_valid,
    output reg rx_last,
    output reg rx_err
);
    reg [7:0] got [0:17];
    reg [7:0] r [0:7];
    integer n = 0;
    integer m;
    integer i;
    task reply;
        begin
            tx_ready <= 1'h0;
            for (i = 0; i < 8; i = i + 1)
                r[i] = 8'h00;
            if (!sync) begin
                m = (got[1] == 8'h4D) ? 5 : 7;
                r[0] = 8'h40;
                r[1] = got[1];
                if (m == 5)
                    {r[2], r[3]} = {got[2], got[3]};
                else
                    {r[2], r[3], r[4], r[5]} = 32'h03596397;
                for (i = 0; i < m - 1; i = i + 1)
                    r[m-1] = r[m-1] ^ r[i];
                if (bad)
                    r[m-1] = ~r[m-1];
            end else if (got[0] == 8'h00) begin
                m = 8;
                {r[5], r[6], r[7]} = 24'h9F4E74;
            end else begin
                m = 3;
                {r[0], r[1], r[2]} = {got[1], 16'h1234};
            end
            for (i = 0; i < m && !mute; i = i + 1) begin
                @(posedge clk);
                rx_data <= r[i];
                rx_valid <= 1'h1;
                rx_last <= (i == m - 1);
                rx_err <= bad && sync && (i == m - 1);
            end
            @(posedge clk);
            rx_valid <= 1'h0;
            rx_last <= 1'h0;
            rx_err <= 1'h0;
            rx_data <= ~r[m-1];
        end
    endtask
    initial begin
        {tx_ready, rx_valid, rx_last, rx_err, rx_data} = 12'h000;
        forever begin
            @(posedge clk);
            if (tx_valid && tx_ready) begin
                got[n] = tx_data;
                n = tx_last ? 0 : n + 1;
            end
            // ready is driven once per edge, by reply on the last byte
            if (tx_valid && tx_ready && tx_last)
                reply;
            else
                tx_ready <= slow ? ~tx_ready : 1'h1;
        end
    end
endmodule // ecp_enc_model

/* File: verif/testbench.sv */
// self-checking bench for the encoder comms pass-through block
`timescale 1ns/1ps
`include "ecp_defs.vh"
module testbench;
    reg clk = 1'h0, rstn = 1'h0, cyc = 1'h0, we = 1'h0;
    reg slow = 1'h0, mute = 1'h0, bad = 1'h0;
    reg [31:0] codes = 32'h05040301;
    reg [7:0] adr = 8'h00;
    reg [15:0] wdat = 16'h0000, v;
    wire [31:0] rdat;
    wire ack, irq, pcd, sync, txl, txv, txr, rxv, rxl, rxe;
    wire [7:0] txd, rxd;
    integer fail_count = 0, n_compared = 0, k;
    always #5 clk = ~clk;
    ecp_encoder_comms #(.TIMEOUT_CYC(50)) ecp_encoder_comms_i (
        .clk(clk), .rstn(rstn), .ce(1'h1), .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3),
        .wb_dat_i({16'h0000, wdat}), .wb_dat_o(rdat), .wb_ack_o(ack),
        .enc_tx_data(txd), .enc_tx_last(txl), .enc_tx_valid(txv),
        .enc_tx_ready(txr), .enc_rx_data(rxd), .enc_rx_valid(rxv),
        .enc_rx_last(rxl), .enc_rx_err(rxe), .position_check_disable(pcd),
        .sync_link_mode(sync), .irq(irq));
    ecp_enc_model ecp_enc_model_i (.clk(clk), .sync(sync), .slow(slow),
        .mute(mute), .bad(bad), .tx_data(txd), .tx_last(txl),
        .tx_valid(txv),
        .tx_ready(txr), .rx_data(rxd), .rx_valid(rxv), .rx_last(rxl),
        .rx_err(rxe));
    task conclude;
        begin
            if (fail_count == 0 && n_compared > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask
    task chk(input [15:0] seen, input [15:0] exp);
        begin
            n_compared = n_compared + 1;
            if (seen !== exp) begin
                fail_count = fail_count + 1;
                $display("mismatch at %0t: got %h want %h", $time, seen, exp);
            end
        end
    endtask
    // one classic cycle, result of a read left in v
    task bus(input [7:0] a, input w, input [15:0] d);
        integer t;
        begin
            adr <= a;
            we <= w;
            wdat <= d;
            cyc <= 1'h1;
            t = 0;
            @(posedge clk);
            while (ack !== 1'h1 && t < 50) begin
                @(posedge clk);
                t = t + 1;
            end
            v = rdat[15:0];
            cyc <= 1'h0;
            @(posedge clk);
            if (t == 50)
                fail_count = fail_count + 1;
        end
    endtask
    task txw(input [15:0] w);
        integer t;
        begin
            v = 16'hFFFF;
            for (t = 0; t < 100 && v !== 16'h0000; t = t + 1)
                bus(`ECP_ADR_TX, 1'h0, 16'h0000);
            chk(v, 16'h0000);
            bus(`ECP_ADR_TX, 1'h1, w);
        end
    endtask
    task rxw(input [15:0] e);
        integer t;
        begin
            v = 16'h0000;
            for (t = 0; t < 200 && v === 16'h0000; t = t + 1)
                bus(`ECP_ADR_RX, 1'h0, 16'h0000);
            chk(v, e);
            bus(`ECP_ADR_RX, 1'h1, 16'h0000);
        end
    endtask
    task rxn(input [127:0] s, input integer n);
        integer i;
        begin
            for (i = n - 1; i >= 0; i = i - 1)
                rxw(s[16*i +: 16]);
        end
    endtask
    initial begin
        #400000;
        fail_count = fail_count + 1;
        conclude;
    end
    initial begin
        repeat (8) @(posedge clk);
        rstn <= 1'h1;
        @(posedge clk);
        bus(`ECP_ADR_CTRL, 1'h0, 16'h0000);
        chk(v, 16'h0000);
        bus(8'h14, 1'h0, 16'h0000);
        chk(v, 16'h0000);
        bus(`ECP_ADR_IRQ_MASK, 1'h1, 16'h0000);
        bus(`ECP_ADR_TX, 1'h1, 16'hA0FF);
        bus(`ECP_ADR_TX, 1'h0, 16'h0000);
        chk(v, 16'hA0FF);
        bus(`ECP_ADR_CTRL, 1'h1, 16'h0001);
        txw(16'hC042);
        rxn({64'h8040804280038059, 48'h80638097C0AC}, 7);
        chk({8'h00, ecp_enc_model_i.got[2]}, 16'h00BD);
        chk({15'h0, irq}, 16'h0000);
        bus(`ECP_ADR_IRQ_STAT, 1'h0, 16'h0000);
        chk(v, 16'h0005);
        bus(`ECP_ADR_IRQ_MASK, 1'h1, 16'h0001);
        chk({15'h0, irq}, 16'h0001);
        bus(`ECP_ADR_IRQ_STAT, 1'h1, 16'h0007);
        chk({15'h0, irq}, 16'h0000);
        txw(16'hA0FF);
        txw(16'h804D);
        txw(16'h8002);
        txw(16'h8065);
        txw(16'hC055);
        rxn(80'h8040804D80028065C06A, 5);
        chk({8'h00, ecp_enc_model_i.got[5]}, 16'h0080);
        bus(`ECP_ADR_CTRL, 1'h1, 16'h0003);
        txw(16'hE000);
        rxn({80'h80008000800080008000, 48'h809F804EC074}, 8);
        slow <= 1'h1;
        for (k = 0; k < 4; k = k + 1) begin
            txw({8'hA0, codes[8 * k +: 8]});
            txw(16'h8000);
            txw(16'h8012);
            txw(16'hC034);
            rxn(48'h80008012C034, 3);
        end
        slow <= 1'h0;
        txw(16'hE002);
        rxw(16'h2004);
        bus(`ECP_ADR_CTRL, 1'h1, 16'h0001);
        txw(16'hA0FF);
        for (k = 0; k < 14; k = k + 1)
            txw(16'h8001);
        txw(16'hC001);
        rxw(16'h2002);
        bad <= 1'h1;
        txw(16'hA0FF);
        txw(16'hC042);
        rxw(16'h2010);
        bus(`ECP_ADR_CTRL, 1'h1, 16'h0003);
        txw(16'hE000);
        rxw(16'h2008);
        bad <= 1'h0;
        bus(`ECP_ADR_CTRL, 1'h1, 16'h0001);
        mute <= 1'h1;
        txw(16'hA0FF);
        txw(16'hC042);
        rxw(16'h2020);
        conclude;
    end
endmodule // testbench
